// >>> include/ovr_pkg.sv
// Constants for the output over-voltage fault reaction block.
// Assumes a single 125 MHz system clock; the delay time unit arrives as a cycle count.
package ovr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OVR_REACTION_CODE  = 8'h41;
  localparam logic [7:0] OVR_REACTION_RESET = 8'h80;

  // ----------------------------------------------------------------
  // Field layout of the reaction byte
  // ----------------------------------------------------------------
  localparam int         OVR_MODE_MSB  = 7;
  localparam int         OVR_MODE_LSB  = 6;
  localparam int         OVR_RETRY_MSB = 5;
  localparam int         OVR_RETRY_LSB = 3;
  localparam int         OVR_DLY_MSB   = 2;
  localparam int         OVR_DLY_LSB   = 0;
  localparam logic [1:0] OVR_MODE_IGNORE  = 2'h0;
  localparam logic [1:0] OVR_MODE_DELAYED = 2'h1;
  localparam logic [1:0] OVR_MODE_SHUTDN  = 2'h2;
  localparam logic [1:0] OVR_MODE_HOLD    = 2'h3;
  localparam logic [2:0] OVR_RETRY_NONE   = 3'h0;
  localparam logic [2:0] OVR_RETRY_ALWAYS = 3'h7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         OVR_UNIT_W  = 16;
  localparam int         OVR_TMR_W   = 23;
  localparam logic [OVR_TMR_W-1:0] OVR_TMR_ONE = 23'h000001;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_RUN,
    ST_DELAY,
    ST_HOLD,
    ST_WAIT,
    ST_TRY,
    ST_LATCH
  } ovr_state_t;

endpackage

// >>> core/ovr_core.sv
// Output over-voltage fault reaction: reaction byte, retry sequencer and output enable.
// Assumes the command decoder delivers byte writes on the system clock, and the fault,
// control and bias pins arrive asynchronously.
`timescale 1ns/1ns
module ovr_core
  import ovr_pkg::*;
(
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_arst_n,
  input  wire logic [7:0]            i_cmd_code,
  input  wire logic                  i_wr_stb,
  input  wire logic [7:0]            i_wr_data,
  output logic      [7:0]            o_rd_data,
  input  wire logic [OVR_UNIT_W-1:0] i_time_unit,
  input  wire logic                  i_clear_faults,
  input  wire logic                  i_op_on,
  input  wire logic                  i_other_shutdown,
  input  wire logic                  i_ov_fault,
  input  wire logic                  i_ctrl_on,
  input  wire logic                  i_bias_ok,
  output logic                       o_vout_en,
  output logic                       o_fault_latched,
  output logic      [2:0]            o_attempts
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end
    else
    begin
      sync1_r <= {i_bias_ok, i_ctrl_on, i_ov_fault};
      sync2_r <= sync1_r;
    end
  end

  wire ov_s   = sync2_r[0];
  wire kill   = !(sync2_r[1] && i_op_on) || !sync2_r[2] || i_other_shutdown;

  // ----------------------------------------------------------------
  // Reaction byte
  // ----------------------------------------------------------------
  logic [7:0] cfg_r;

  wire        cfg_hit = i_cmd_code == OVR_REACTION_CODE;
  wire [1:0]  mode    = cfg_r[OVR_MODE_MSB:OVR_MODE_LSB];
  wire [2:0]  retry   = cfg_r[OVR_RETRY_MSB:OVR_RETRY_LSB];
  wire [2:0]  dly_exp = cfg_r[OVR_DLY_MSB:OVR_DLY_LSB];

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      cfg_r <= OVR_REACTION_RESET;
    else if (i_wr_stb && cfg_hit)
      cfg_r <= i_wr_data;
  end

  assign o_rd_data = cfg_hit ? cfg_r : 8'h00;

  // ----------------------------------------------------------------
  // Delay and retry bookkeeping
  // ----------------------------------------------------------------
  // Unit width plus the largest exponent fits the timer exactly; no wrap possible.
  wire [OVR_TMR_W-1:0] dly_load = {7'h00, i_time_unit} << dly_exp;

  ovr_state_t          st_r;
  ovr_state_t          st_nxt;
  logic [OVR_TMR_W-1:0] tmr_r;
  logic [OVR_TMR_W-1:0] tmr_nxt;
  logic [2:0]           att_r;
  logic [2:0]           att_nxt;
  logic                 out_en_r;

  wire tmr_done  = tmr_r <= OVR_TMR_ONE;
  wire continuous = retry == OVR_RETRY_ALWAYS;
  wire more_tries = continuous || (att_r < retry);
  wire [OVR_TMR_W-1:0] tmr_dec = (tmr_r != '0) ? tmr_r - OVR_TMR_ONE : tmr_r;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt  = st_r;
    tmr_nxt = tmr_dec;
    att_nxt = att_r;
    unique case (st_r)
      ST_OFF:
      begin
        st_nxt  = ST_RUN;
        att_nxt = 3'h0;
      end
      ST_RUN:
        if (ov_s)
        begin
          unique case (mode)
            OVR_MODE_IGNORE:  st_nxt = ST_RUN;
            OVR_MODE_DELAYED:
            begin
              st_nxt  = ST_DELAY;
              tmr_nxt = dly_load;
            end
            OVR_MODE_SHUTDN:
            begin
              st_nxt  = (retry == OVR_RETRY_NONE) ? ST_LATCH : ST_WAIT;
              tmr_nxt = dly_load;
            end
            OVR_MODE_HOLD:    st_nxt = ST_HOLD;
          endcase
        end
      ST_DELAY:
        if (tmr_done)
        begin
          if (!ov_s)
            st_nxt = ST_RUN;
          else
          begin
            st_nxt  = (retry == OVR_RETRY_NONE) ? ST_LATCH : ST_WAIT;
            tmr_nxt = dly_load;
          end
        end
      ST_HOLD:
        if (!ov_s)
          st_nxt = ST_RUN;
      ST_WAIT:
        if (tmr_done)
        begin
          if (more_tries)
          begin
            st_nxt  = ST_TRY;
            tmr_nxt = dly_load;
            att_nxt = continuous ? att_r : att_r + 3'h1;
          end
          else
            st_nxt = ST_LATCH;
        end
      // A failed attempt keeps the running timer so attempts start a full delay apart
      ST_TRY:
        if (ov_s)
          st_nxt = ST_WAIT;
        else if (tmr_done)
        begin
          st_nxt  = ST_RUN;
          att_nxt = 3'h0;
        end
      ST_LATCH:
        if (i_clear_faults)
          st_nxt = ST_OFF;
    endcase
    if (kill)
    begin
      st_nxt  = ST_OFF;
      att_nxt = 3'h0;
    end
  end

  wire en_nxt = (st_nxt == ST_RUN) || (st_nxt == ST_DELAY) || (st_nxt == ST_TRY);

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_r     <= ST_OFF;
      tmr_r    <= '0;
      att_r    <= 3'h0;
      out_en_r <= 1'b0;
    end
    else
    begin
      st_r     <= st_nxt;
      tmr_r    <= tmr_nxt;
      att_r    <= att_nxt;
      out_en_r <= en_nxt;
    end
  end

  assign o_vout_en       = out_en_r;
  assign o_fault_latched = st_r == ST_LATCH;
  assign o_attempts      = att_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_arst_n);

  sequence s_shut_request;
    st_r == ST_RUN && ov_s && !kill && mode == OVR_MODE_SHUTDN;
  endsequence

  a_ignore_keeps_on: assert property (
    (st_r == ST_RUN && ov_s && !kill && mode == OVR_MODE_IGNORE)
      |=> (st_r == ST_RUN && o_vout_en))
    else $error("ignore mode interrupted the output");
  a_delay_runs_on: assert property (
    (st_r == ST_DELAY) |-> o_vout_en)
    else $error("output off during fault delay");
  a_delay_loaded: assert property (
    (st_r == ST_RUN && ov_s && !kill && mode == OVR_MODE_DELAYED) |=> tmr_r == $past(dly_load))
    else $error("fault delay not loaded with scaled count");
  a_shut_now: assert property (
    s_shut_request |=> !o_vout_en)
    else $error("shutdown mode left the output on");
  a_no_retry_latch: assert property (
    (s_shut_request ##0 retry == OVR_RETRY_NONE) |=> o_fault_latched)
    else $error("zero retries did not latch off");
  a_latch_holds: assert property (
    (st_r == ST_LATCH && !i_clear_faults && !kill) |=> (st_r == ST_LATCH && !o_vout_en))
    else $error("latched fault released without clear");
  a_hold_resume: assert property (
    (st_r == ST_HOLD && !ov_s && !kill) |=> o_vout_en ##0 st_r == ST_RUN)
    else $error("hold mode did not resume");
  a_try_counted: assert property (
    (st_r == ST_WAIT && tmr_done && !kill && !continuous && att_r < retry)
      |=> (st_r == ST_TRY && att_r == $past(att_r) + 3'h1))
    else $error("restart attempt not counted");
  a_kill_stops: assert property (
    kill |=> (st_r == ST_OFF && !o_vout_en))
    else $error("off command did not stop the sequence");
  a_clear_release: assert property (
    (st_r == ST_LATCH && i_clear_faults && !kill)
      |=> st_r == ST_OFF ##1 (st_r == ST_RUN || $past(kill)))
    else $error("clear did not allow start-up");

endmodule

// >>> sim/ovr_host_model.sv
// Host stand-in: writes and selects reaction registers, issues clear-faults.
// Assumes the block samples code, strobe and data on the rising clock edge.
`timescale 1ns/1ns
module ovr_host_model
(
  input  wire logic       i_clk_sys,
  output logic      [7:0] o_cmd_code,
  output logic            o_wr_stb,
  output logic      [7:0] o_wr_data,
  output logic            o_clear
);
  initial
  begin
    o_cmd_code = 8'h41;
    o_wr_stb   = 1'b0;
    o_wr_data  = 8'h00;
    o_clear    = 1'b0;
  end
  task automatic sel(input logic [7:0] code);
    @(posedge i_clk_sys);
    o_cmd_code <= code;
  endtask
  task automatic wr(input logic [7:0] code, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_cmd_code <= code;
    o_wr_stb   <= 1'b1;
    o_wr_data  <= d;
    @(posedge i_clk_sys);
    o_cmd_code <= 8'h41;
    o_wr_stb   <= 1'b0;
    o_wr_data  <= ~d;
  endtask
  // One-cycle pulse is enough; the latch must not need a held level
  task automatic clr();
    @(posedge i_clk_sys);
    o_clear <= 1'b1;
    @(posedge i_clk_sys);
    o_clear <= 1'b0;
  endtask
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the over-voltage reaction block.
// Assumes one 125 MHz clock; unit 2 or 4 cycles keeps retry delays short.
`timescale 1ns/1ns
module testbench;
  import ovr_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic fault = 1'b0;
  logic [3:0] kill = 4'h0;
  logic [15:0] unit = 16'h0002;
  logic [7:0] code, wdat, rd;
  logic stb, clear, en, lat;
  logic [2:0] att;
  int error_cnt = 0;
  int num_checks = 0;
  always #4 clk = ~clk;
  ovr_host_model host (.i_clk_sys(clk), .o_cmd_code(code), .o_wr_stb(stb),
    .o_wr_data(wdat), .o_clear(clear));
  ovr_core dut_u (.i_clk_sys(clk), .i_arst_n(arst_n), .i_cmd_code(code),
    .i_wr_stb(stb), .i_wr_data(wdat), .o_rd_data(rd), .i_time_unit(unit),
    .i_clear_faults(clear), .i_op_on(~kill[1]), .i_other_shutdown(kill[3]),
    .i_ov_fault(fault), .i_ctrl_on(~kill[0]), .i_bias_ok(~kill[2]),
    .o_vout_en(en), .o_fault_latched(lat), .o_attempts(att));
  task automatic summarize();
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait on the output enable; n returns the cycles spent
  task automatic wait_en(input logic v, input int lim, output int n);
    n = 0;
    num_checks++;
    // Step off the edge so an enable launched there is settled
    #1;
    while (en !== v)
    begin
      cyc(1);
      n++;
      if (n > lim)
      begin
        error_cnt++;
        $display("[FAIL] vout_en wait expected %b seen %b", v, en);
        summarize();
      end
    end
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_regs();
    chk("reset_byte", rd, 8'h80);
    host.wr(8'h40, 8'h3F);
    host.sel(8'h40);
    cyc(1);
    chk("other_code", rd, 8'h00);
    host.sel(8'h41);
    cyc(1);
    chk("ignored_wr", rd, 8'h80);
  endtask
  task automatic t_modes();
    int n;
    host.wr(8'h41, 8'h00);
    @(posedge clk) fault <= 1'b1;
    cyc(20);
    chk("ignore_en", {7'h0, en}, 8'h01);
    @(posedge clk) fault <= 1'b0;
    host.wr(8'h41, 8'hC0);
    @(posedge clk) fault <= 1'b1;
    wait_en(1'b0, 5, n);
    cyc(10);
    chk("hold_lat", {7'h0, lat}, 8'h00);
    @(posedge clk) fault <= 1'b0;
    wait_en(1'b1, 6, n);
    host.wr(8'h41, 8'h42);
    #1;
    chk("wr_back", rd, 8'h42);
    @(posedge clk) fault <= 1'b1;
    cyc(4);
    @(posedge clk) fault <= 1'b0;
    cyc(16);
    chk("dly_gone", {6'h0, lat, en}, 8'h01);
    @(posedge clk) fault <= 1'b1;
    cyc(9);
    chk("dly_run", {7'h0, en}, 8'h01);
    wait_en(1'b0, 6, n);
    cyc(2);
    chk("dly_latch", {7'h0, lat}, 8'h01);
    @(posedge clk) fault <= 1'b0;
    host.clr();
    wait_en(1'b1, 8, n);
  endtask
  task automatic t_retry();
    int n, n1, n2;
    for (int r = 0; r < 7; r++)
    begin
      host.wr(8'h41, {2'b10, r[2:0], 3'b010});
      @(posedge clk) fault <= 1'b1;
      wait_en(1'b0, 6, n);
      for (int a = 1; a <= r; a++)
      begin
        wait_en(1'b1, 12, n2);
        if (a > 1)
          chk("try_gap", 8'(n1 + n2), 8'h08);
        wait_en(1'b0, 4, n1);
      end
      cyc(12);
      chk("tries", {5'h0, att}, {5'h0, r[2:0]});
      @(posedge clk) fault <= 1'b0;
      cyc(6);
      chk("latched", {6'h0, lat, en}, 8'h02);
      host.clr();
      wait_en(1'b1, 8, n);
    end
    // Fault gone during the wait: the single attempt succeeds and the count restarts
    host.wr(8'h41, 8'h8A);
    @(posedge clk) fault <= 1'b1;
    wait_en(1'b0, 6, n);
    @(posedge clk) fault <= 1'b0;
    wait_en(1'b1, 12, n);
    chk("restart_cnt", {5'h0, att}, 8'h01);
    cyc(12);
    chk("restart_clr", {5'h0, att}, 8'h00);
    chk("restart_on", {6'h0, lat, en}, 8'h01);
  endtask
  task automatic t_cont();
    int n, rises;
    logic prev;
    @(posedge clk) unit <= 16'h0004;
    host.wr(8'h41, 8'hB8);
    for (int k = 0; k < 4; k++)
    begin
      rises = 0;
      prev = en;
      @(posedge clk) fault <= 1'b1;
      repeat (80)
      begin
        cyc(1);
        if (en === 1'b1 && prev === 1'b0)
          rises++;
        prev = en;
      end
      chk("cont_tries", 8'(rises > 10), 8'h01);
      chk("cont_state", {4'h0, att, lat}, 8'h00);
      @(posedge clk) kill <= 4'h1 << k;
      cyc(6);
      chk("killed", {4'h0, att, en}, 8'h00);
      rises = 0;
      repeat (20)
      begin
        cyc(1);
        if (en !== 1'b0)
          rises++;
      end
      chk("kill_quiet", 8'(rises), 8'h00);
      @(posedge clk) fault <= 1'b0;
      @(posedge clk) kill <= 4'h0;
      wait_en(1'b1, 10, n);
    end
  endtask
  initial
  begin
    int n;
    cyc(6);
    @(posedge clk) arst_n <= 1'b1;
    wait_en(1'b1, 10, n);
    t_regs();
    t_modes();
    t_retry();
    t_cont();
    summarize();
  end
endmodule
